/* File: tbc_timer.sv */
// Purpose: channel B control, counter and compare registers of a 10-bit timer
// Assumes: count_tick marks edges of the selected counting clock
// Notes: registers over axi4-lite; capture loads compare B
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
module tbc_timer
    import tbc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NPIN = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic count_tick,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] chan_b_pin_in,
    output logic [NPIN-1:0] chan_b_pin_out,
    output logic [NPIN-1:0] chan_b_pin_oe
);
    generate
        if (ADDR_W < 8 || ADDR_W > 32 || NPIN < 1)
            $error("tbc_timer: ADDR_W must be 8..32 and NPIN at least 1");
    endgenerate

    logic [7:0] timer_control;
    logic [7:0] channel_b_control;
    logic [CNT_W-1:0] cnt;
    logic count_down;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] compare_b_value;
    logic [1:0] status;
    logic on_prev;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic capt_hit;

    wire module_on = timer_control[ON_BIT];
    wire tbc_mode_e chan_b_mode_sel = tbc_mode_e'(channel_b_control[B_MODE_LSB +: 2]);
    wire tbc_mode_e chan_a_mode_sel = tbc_mode_e'(timer_control[A_MODE_LSB +: 2]);
    wire [1:0] chan_b_pin_function = channel_b_control[B_FUNC_LSB +: 2];
    wire chan_b_output_level_ctrl = channel_b_control[B_OC_BIT];
    wire chan_b_invert = channel_b_control[B_INV_BIT];
    wire [1:0] pwm_alignment_sel = channel_b_control[ALIGN_LSB +: 2];
    wire on_rise = module_on & ~on_prev;
    wire centre = (chan_b_mode_sel == TBC_PWM) && (pwm_alignment_sel != ALIGN_EDGE);
    wire step = module_on & count_tick;

    // direction qualifier of the match in centre alignment
    wire dir_ok = !centre || (pwm_alignment_sel == ALIGN_UP && !count_down) ||
                  (pwm_alignment_sel == ALIGN_DOWN && count_down) ||
                  (pwm_alignment_sel == ALIGN_BOTH);
    wire match_b = step && (cnt == compare_b_value) && dir_ok;
    wire pwm_active = cnt < compare_b_value;

    // write decode
    wire do_write = aw_got & w_got;
    wire wr_lane = do_write & w_strb[0];
    wire wr_ctrl = wr_lane && aw_addr == OFS_TIMER_CTRL;
    wire wr_b_ctrl = wr_lane && aw_addr == OFS_CHAN_B_CTRL;
    wire wr_a_low = wr_lane && aw_addr == OFS_CMP_A_LOW;
    wire wr_a_high = wr_lane && aw_addr == OFS_CMP_A_HIGH;
    wire wr_b_low = wr_lane && aw_addr == OFS_CMP_B_LOW;
    wire wr_b_high = wr_lane && aw_addr == OFS_CMP_B_HIGH;
    wire wr_status = wr_lane && aw_addr == OFS_STATUS;
    wire wr_known = (aw_addr == OFS_TIMER_CTRL) || (aw_addr == OFS_CHAN_B_CTRL) ||
                    (aw_addr == OFS_CNT_LOW) || (aw_addr == OFS_CNT_HIGH) ||
                    (aw_addr == OFS_CMP_A_LOW) || (aw_addr == OFS_CMP_A_HIGH) ||
                    (aw_addr == OFS_CMP_B_LOW) || (aw_addr == OFS_CMP_B_HIGH) ||
                    (aw_addr == OFS_STATUS);
    wire [7:0] wbyte = w_data[7:0];

    // read decode; high registers return zero above bit 1
    wire [7:0] rd_addr = s_axi_araddr[7:0];
    wire rd_known = (ADDR_W == 8 || s_axi_araddr[ADDR_W-1:0] < 9'h100) && (
                    rd_addr == OFS_TIMER_CTRL || rd_addr == OFS_CHAN_B_CTRL ||
                    rd_addr == OFS_CNT_LOW || rd_addr == OFS_CNT_HIGH ||
                    rd_addr == OFS_CMP_A_LOW || rd_addr == OFS_CMP_A_HIGH ||
                    rd_addr == OFS_CMP_B_LOW || rd_addr == OFS_CMP_B_HIGH ||
                    rd_addr == OFS_STATUS);
    wire [7:0] rd_byte =
        (rd_addr == OFS_TIMER_CTRL) ? timer_control :
        (rd_addr == OFS_CHAN_B_CTRL) ? channel_b_control :
        (rd_addr == OFS_CNT_LOW) ? cnt[7:0] :
        (rd_addr == OFS_CNT_HIGH) ? {6'h00, cnt[9:8]} :
        (rd_addr == OFS_CMP_A_LOW) ? compare_a_value[7:0] :
        (rd_addr == OFS_CMP_A_HIGH) ? {6'h00, compare_a_value[9:8]} :
        (rd_addr == OFS_CMP_B_LOW) ? compare_b_value[7:0] :
        (rd_addr == OFS_CMP_B_HIGH) ? {6'h00, compare_b_value[9:8]} :
        (rd_addr == OFS_STATUS) ? {6'h00, status} : 8'h00;

    // write channel: address and data accepted in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got <= 1'b1;
                aw_addr <= (ADDR_W == 8 || s_axi_awaddr[ADDR_W-1:0] < 9'h100) ? s_axi_awaddr[7:0] : 8'hff;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: one outstanding read, answer one cycle after acceptance
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // control registers; mode changes while running are the software's care
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timer_control <= CTRL_RST;
            channel_b_control <= CTRL_RST;
            on_prev <= 1'b0;
        end
        else if (ce)
        begin
            on_prev <= module_on;
            if (wr_ctrl)
                timer_control <= wbyte;
            if (wr_b_ctrl)
                channel_b_control <= wbyte;
        end
    end

    // compare values; a capture overrides a same-cycle software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            compare_a_value <= CMP_RST;
            compare_b_value <= CMP_RST;
        end
        else if (ce)
        begin
            if (wr_a_low)
                compare_a_value[7:0] <= wbyte;
            if (wr_a_high)
                compare_a_value[9:8] <= wbyte[1:0];
            if (capt_hit)
                compare_b_value <= cnt;
            else if (wr_b_low)
                compare_b_value[7:0] <= wbyte;
            else if (wr_b_high)
                compare_b_value[9:8] <= wbyte[1:0];
        end
    end

    // counter: no write path, so it stays read-only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= CMP_RST;
            count_down <= 1'b0;
        end
        else if (ce)
        begin
            if (on_rise)
            begin
                cnt <= CMP_RST;
                count_down <= 1'b0;
            end
            else if (step && centre)
            begin
                if (!count_down && cnt == CNT_MAX)
                    count_down <= 1'b1;
                else if (count_down && cnt == CMP_RST)
                    count_down <= 1'b0;
                cnt <= (count_down ? (cnt == CMP_RST) : (cnt != CNT_MAX)) ?
                       cnt + 10'h001 : cnt - 10'h001;
            end
            else if (step)
                cnt <= cnt + 10'h001;
        end
    end

    // sticky status: hardware set wins over a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status <= 2'b00;
        else if (ce)
        begin
            status[ST_MATCH_BIT] <= match_b | (status[ST_MATCH_BIT] & ~(wr_status & wbyte[ST_MATCH_BIT]));
            status[ST_CAPT_BIT] <= capt_hit | (status[ST_CAPT_BIT] & ~(wr_status & wbyte[ST_CAPT_BIT]));
        end
    end

    tbc_pin_stage #(
        .NPIN(NPIN)
    ) tbc_pin_stage_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .mode(chan_b_mode_sel),
        .func(chan_b_pin_function),
        .oc(chan_b_output_level_ctrl),
        .inv(chan_b_invert),
        .on_rise(on_rise),
        .pwm_active(pwm_active),
        .match_b(match_b),
        .pin_in(chan_b_pin_in),
        .pin_out(chan_b_pin_out),
        .pin_oe(chan_b_pin_oe),
        .capt_hit(capt_hit)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_counter_restart: assert property (ce && on_rise |=> cnt == CMP_RST)
        else $error("counter not cleared when timer switched on");
    chk_counter_keep: assert property (ce && !module_on && !on_prev ##1 ce && !module_on |-> $stable(cnt))
        else $error("counter moved while timer off");
    chk_high_zero: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rdata[31:2] == 30'h0 ||
        $past(rd_addr) != OFS_CNT_HIGH && $past(rd_addr) != OFS_CMP_A_HIGH && $past(rd_addr) != OFS_CMP_B_HIGH)
        else $error("high register upper bits not zero");
    chk_cmp_a_write: assert property (ce && wr_a_low |=> compare_a_value[7:0] == $past(wbyte))
        else $error("compare A low byte not stored");
    chk_cmp_b_write: assert property (ce && wr_b_high && !capt_hit |=> compare_b_value[9:8] == $past(wbyte[1:0]))
        else $error("compare B high bits not stored");
    chk_timer_undriven: assert property (ce && chan_b_mode_sel == TBC_TMR |=> chan_b_pin_oe == '0)
        else $error("pins driven in timer mode");
    chk_restore_level: assert property (ce && on_rise && chan_b_mode_sel == TBC_CMP |=>
        chan_b_pin_out[0] == (chan_b_output_level_ctrl ^ chan_b_invert))
        else $error("pin not restored to initial level");
    chk_match_flag: assert property (ce && match_b |=> status[ST_MATCH_BIT])
        else $error("match B not flagged");
    chk_force_level: assert property (ce && chan_b_mode_sel == TBC_PWM && chan_b_pin_function == FN_INACTIVE |=>
        chan_b_pin_out[0] == ~($past(chan_b_output_level_ctrl) ^ $past(chan_b_invert)))
        else $error("forced inactive level wrong");
    chk_bus_answer: assert property (ce && do_write |=> s_axi_bvalid [*1] ##0 !aw_got)
        else $error("write not answered");

    cov_match_cmp: cover property (ce && match_b && chan_b_mode_sel == TBC_CMP);
    cov_capture: cover property (ce && capt_hit);
    cov_centre_down: cover property (ce && step && centre && count_down);
endmodule : tbc_timer

/* File: tbc_pkg.sv */
// Purpose: shared constants and types for the channel B compare/pwm timer block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes: register data sits in the low byte, upper bits read as zero
package tbc_pkg;
    localparam int CNT_W = 10;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAN_B_CTRL = 8'h04;
    localparam logic [7:0] OFS_CNT_LOW = 8'h08;
    localparam logic [7:0] OFS_CNT_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CMP_A_LOW = 8'h10;
    localparam logic [7:0] OFS_CMP_A_HIGH = 8'h14;
    localparam logic [7:0] OFS_CMP_B_LOW = 8'h18;
    localparam logic [7:0] OFS_CMP_B_HIGH = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // timer control: module_on and chan_a_mode_sel
    localparam int ON_BIT = 0;
    localparam int A_MODE_LSB = 6;
    // channel_b_control layout
    localparam int B_MODE_LSB = 6;
    localparam int B_FUNC_LSB = 4;
    localparam int B_OC_BIT = 3;
    localparam int B_INV_BIT = 2;
    localparam int ALIGN_LSB = 0;
    // status: sticky, write one to clear
    localparam int ST_MATCH_BIT = 0;
    localparam int ST_CAPT_BIT = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [CNT_W-1:0] CMP_RST = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        TBC_CMP = 2'b00,
        TBC_CAPT = 2'b01,
        TBC_PWM = 2'b10,
        TBC_TMR = 2'b11
    } tbc_mode_e;
    // pin function codes, meaning depends on mode
    localparam logic [1:0] FN_KEEP = 2'b00;
    localparam logic [1:0] FN_LOW = 2'b01;
    localparam logic [1:0] FN_HIGH = 2'b10;
    localparam logic [1:0] FN_TOGGLE = 2'b11;
    localparam logic [1:0] FN_INACTIVE = 2'b00;
    localparam logic [1:0] FN_ACTIVE = 2'b01;
    localparam logic [1:0] FN_PWM = 2'b10;
    localparam logic [1:0] FN_PULSE = 2'b11;
    localparam logic [1:0] FN_CAP_RISE = 2'b00;
    localparam logic [1:0] FN_CAP_FALL = 2'b01;
    localparam logic [1:0] FN_CAP_BOTH = 2'b10;
    localparam logic [1:0] ALIGN_EDGE = 2'b00;
    localparam logic [1:0] ALIGN_UP = 2'b01;
    localparam logic [1:0] ALIGN_DOWN = 2'b10;
    localparam logic [1:0] ALIGN_BOTH = 2'b11;
    typedef enum logic [1:0] {
        TBC_SP_IDLE = 2'b00,
        TBC_SP_FIRE = 2'b01,
        TBC_SP_DONE = 2'b11
    } tbc_pulse_e;
endpackage : tbc_pkg

/* File: tbc_pin_stage.sv */
// Purpose: drives the channel B pins and detects capture edges on them
// Assumes: pin inputs are synchronous to aclk
// Notes: both pins carry the same waveform
module tbc_pin_stage
    import tbc_pkg::*;
#(
    parameter int NPIN = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire tbc_mode_e mode,
    input wire logic [1:0] func,
    input wire logic oc,
    input wire logic inv,
    input wire logic on_rise,
    input wire logic pwm_active,
    input wire logic match_b,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic capt_hit
);
    logic level;
    logic next_level;
    tbc_pulse_e sp_state;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] pin_edge;
    logic drive_en;
    logic act;

    // active level is oc in pwm modes; forced states follow the function
    assign act = (func == FN_ACTIVE) || (func == FN_PWM && pwm_active) ||
                 (func == FN_PULSE && sp_state == TBC_SP_FIRE);
    assign drive_en = (mode == TBC_CMP) || (mode == TBC_PWM);
    always_comb
    begin
        next_level = level;
        unique case (mode)
            TBC_CMP:
            begin
                if (on_rise)
                    next_level = oc;
                else if (match_b)
                begin
                    // a request equal to the present level changes nothing
                    unique case (func)
                        FN_KEEP: next_level = level;
                        FN_LOW: next_level = 1'b0;
                        FN_HIGH: next_level = 1'b1;
                        FN_TOGGLE: next_level = ~level;
                    endcase
                end
            end
            TBC_PWM: next_level = act ? oc : ~oc;
            TBC_CAPT, TBC_TMR: next_level = level;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sp_state <= TBC_SP_IDLE;
        else if (ce)
        begin
            unique case (sp_state)
                TBC_SP_IDLE: if (on_rise) sp_state <= TBC_SP_FIRE;
                TBC_SP_FIRE: if (match_b) sp_state <= TBC_SP_DONE;
                TBC_SP_DONE: if (on_rise) sp_state <= TBC_SP_FIRE;
                default: sp_state <= TBC_SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level <= 1'b0;
        else if (ce)
            level <= next_level;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            assign pin_edge[gi] = (func == FN_CAP_RISE) ? (pin_in[gi] & ~pin_prev[gi]) :
                                  (func == FN_CAP_FALL) ? (~pin_in[gi] & pin_prev[gi]) :
                                  (func == FN_CAP_BOTH) ? (pin_in[gi] ^ pin_prev[gi]) : 1'b0;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pin_prev[gi] <= 1'b0;
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    pin_prev[gi] <= pin_in[gi];
                    pin_out[gi] <= next_level ^ inv;
                    pin_oe[gi] <= drive_en;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            capt_hit <= 1'b0;
        else if (ce)
            capt_hit <= (mode == TBC_CAPT) && (|pin_edge);
    end
endmodule : tbc_pin_stage

/* File: tbc_timer_tb_top.sv */
// Purpose: self-checking bench for the channel B timer block
// Assumes: bench is the axi4-lite master; ce and wstrb held at fixed values
// Notes: random values come from one fixed seed
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tbc_timer_tb_top
    import tbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REGS [7] = '{OFS_CHAN_B_CTRL, OFS_CNT_LOW, OFS_CNT_HIGH, OFS_CMP_A_LOW,
        OFS_CMP_A_HIGH, OFS_CMP_B_LOW, OFS_CMP_B_HIGH};
    logic aclk, aresetn, tick, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, rsp, pin_in, pin_out, pin_oe;
    logic oc, iv;
    logic [9:0] e;
    int err_total, n_compared, cyc, n, k;
    tbc_timer tbc_timer_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .count_tick(tick),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chan_b_pin_in(pin_in), .chan_b_pin_out(pin_out), .chan_b_pin_oe(pin_oe));
    task automatic close_out();
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // address and data are offered together, each dropped at its own taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | (awready === 1'b1);
            w_ok = w_ok | (wready === 1'b1);
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata[7:0];
        r = rresp;
        `CHK(rdata[31:8], 24'h0)
        rready <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] ev);
        logic [7:0] v;
        logic [1:0] r;
        rd(a, v, r);
        `CHK(v, ev)
        `CHK(r, RESP_OKAY)
    endtask : rc
    // channel A always gets the same mode as channel B
    task automatic son(input logic [1:0] m, input logic on);
        wr(OFS_TIMER_CTRL, {m, 5'h0, on});
    endtask : son
    task automatic tk(input int t);
        repeat (t) @(posedge aclk) tick <= 1'b1;
        @(posedge aclk) tick <= 1'b0;
    endtask : tk
    function automatic logic exp_lvl(input logic [1:0] m, input logic [1:0] f, input logic c, input logic aft);
        if (m == TBC_CMP)
            return (!aft || f == FN_KEEP) ? c : ((f == FN_TOGGLE) ? !c : (f == FN_HIGH));
        return (f == FN_ACTIVE || (f != FN_INACTIVE && !aft)) ? c : !c;
    endfunction : exp_lvl
    task automatic cp(input logic [1:0] m, input logic [1:0] f, input logic aft);
        if (m == TBC_CMP || m == TBC_PWM)
        begin
            `CHK(pin_oe, 2'b11)
            `CHK(pin_out, {2{exp_lvl(m, f, oc, aft) ^ iv}})
        end
        else
            `CHK(pin_oe, 2'b00)
    endtask : cp
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end
    initial
    begin
        {aresetn, tick, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, pin_in} = '0;
        void'($urandom(32'h5097));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (REGS[i]) rc(REGS[i], 8'h00);
        `CHK(pin_oe, 2'b11)
        `CHK(pin_out, 2'b00)
        for (int i = 3; i < 7; i++)
        begin
            d = 8'($urandom);
            wr(REGS[i], d);
            rc(REGS[i], i[0] ? d : {6'h0, d[1:0]});
        end
        d = 8'($urandom);
        wr(OFS_CHAN_B_CTRL, d);
        rc(OFS_CHAN_B_CTRL, d);
        wr(OFS_CNT_LOW, 8'hff);
        rc(OFS_CNT_LOW, 8'h00);
        wr(8'h3c, d, RESP_SLVERR);
        rd(8'h3c, d, rsp);
        `CHK(rsp, RESP_SLVERR)
        wr(OFS_CHAN_B_CTRL, 8'h00);
        n = $urandom_range(1000, 256);
        son(TBC_CMP, 1'b1);
        tk(n);
        rc(OFS_CNT_LOW, n[7:0]);
        rc(OFS_CNT_HIGH, {6'h0, n[9:8]});
        son(TBC_CMP, 1'b0);
        tk(4);
        rc(OFS_CNT_LOW, n[7:0]);
        son(TBC_CMP, 1'b1);
        rc(OFS_CNT_LOW, 8'h00);
        for (int m = 0; m < 4; m++)
            for (int f = 0; f < 4; f++)
            begin
                oc = 1'($urandom);
                iv = 1'($urandom);
                k = $urandom_range(20, 1);
                son(m[1:0], 1'b0);
                wr(OFS_CMP_B_LOW, k[7:0]);
                wr(OFS_CMP_B_HIGH, 8'h00);
                wr(OFS_CHAN_B_CTRL, {m[1:0], f[1:0], oc, iv, ALIGN_EDGE});
                son(m[1:0], 1'b1);
                repeat (2) @(posedge aclk);
                cp(m[1:0], f[1:0], 1'b0);
                tk(k + 1);
                repeat (2) @(posedge aclk);
                cp(m[1:0], f[1:0], 1'b1);
            end
        // capture loads compare B with the counter at the chosen pin edge
        for (int f = 0; f < 4; f++)
        begin
            son(TBC_CAPT, 1'b0);
            wr(OFS_CMP_B_LOW, 8'h00);
            wr(OFS_CHAN_B_CTRL, {TBC_CAPT, f[1:0], 4'h0});
            son(TBC_CAPT, 1'b1);
            n = $urandom_range(60, 10);
            tk(n);
            @(posedge aclk) pin_in <= f[0] ? 2'b01 : 2'b10;
            repeat (3) @(posedge aclk);
            e = (f == FN_CAP_RISE || f == FN_CAP_BOTH) ? n[9:0] : 10'h0;
            rc(OFS_CMP_B_LOW, e[7:0]);
            tk(3);
            @(posedge aclk) pin_in <= 2'b00;
            repeat (3) @(posedge aclk);
            if (f == FN_CAP_FALL || f == FN_CAP_BOTH)
                e = n[9:0] + 10'd3;
            rc(OFS_CMP_B_LOW, e[7:0]);
        end
        // centre alignment: the match counts only in the chosen direction
        for (int a = 1; a < 4; a++)
        begin
            k = $urandom_range(20, 1);
            son(TBC_PWM, 1'b0);
            wr(OFS_CMP_B_LOW, k[7:0]);
            wr(OFS_CMP_B_HIGH, 8'h00);
            wr(OFS_CHAN_B_CTRL, {TBC_PWM, FN_PWM, 2'b10, a[1:0]});
            wr(OFS_STATUS, 8'h03);
            son(TBC_PWM, 1'b1);
            tk(k + 1);
            rc(OFS_STATUS, {7'h0, a != 2});
            wr(OFS_STATUS, 8'h01);
            // up to the top, then down until the counter passes k again
            tk(2046 - 2 * k);
            rc(OFS_STATUS, {7'h0, a != 1});
            rc(OFS_CNT_LOW, 8'(k - 1));
        end
        close_out();
    end
endmodule : tbc_timer_tb_top
